/* File: card_select.v */
// Card selection and character gating for a board on a shared host link.
`timescale 1ns/1ns
`default_nettype none
`include "card_select_defs.vh"
module card_select #(
  parameter SCAN_CYCLES = `SCAN_CYCLES,
  parameter [11:0] BUS_BASE = 12'h000
) (
  input  wire        sys_clk_i,
  input  wire        rst_b_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        card_num_jumper_bit0_i,
  input  wire        card_num_jumper_bit1_i,
  input  wire        card_num_jumper_bit2_i,
  input  wire        card_num_jumper_bit3_i,
  input  wire        card_num_switch_bit0_i,
  input  wire        card_num_switch_bit1_i,
  input  wire        card_num_switch_bit2_i,
  input  wire        card_num_switch_bit3_i,
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_char_i,
  input  wire        cts_i,
  input  wire        tx_valid_i,
  input  wire [7:0]  tx_char_i,
  input  wire        tx_rts_i,
  output reg         tx_data_o,
  output reg         tx_data_oe_o,
  output reg         rts_o,
  output reg         rts_oe_o,
  output reg         tx_hold_o,
  output reg         scan_tick_o,
  output reg         cmd_valid_o,
  output reg  [7:0]  cmd_char_o,
  output reg         ctrl_valid_o,
  output reg  [7:0]  ctrl_char_o,
  output reg         line_go_o,
  output reg         line_noop_o
);
  ////////////////////////////////////////////////////////////////////////
  reg  [1:0]  mode_q;
  reg         swcfg_q;
  reg         addressed_q;
  reg         all_q;
  reg         at_seen_q;
  reg         sel_pend_q;
  reg         sel_all_q;
  reg         sel_hit_q;
  reg         line_has_q;
  reg         line_q;
  reg         cr_pend_q;
  reg         err_q;
  reg         ctrl_seen_q;
  reg         query_rej_q;
  reg  [7:0]  last_rx_q;
  reg  [7:0]  last_tx_q;
  reg  [31:0] scan_cnt_q;
  reg         rst_seen_q;
  reg         chain_q;
  wire [3:0]  jumper_num;
  wire [3:0]  switch_num;
  wire [3:0]  card_num;
  wire [3:0]  digit;
  wire        digit_ok;
  wire        chain;
  wire        is_ctrl;
  wire        is_query;
  wire        scan;
  wire        bus_hit;
  wire [11:0] off;

  // Installed jumper reads 0 at the pin, which is card bit 0.
  assign jumper_num = {card_num_jumper_bit3_i, card_num_jumper_bit2_i,
                       card_num_jumper_bit1_i, card_num_jumper_bit0_i};
  // Closed switch reads 1.
  assign switch_num = {card_num_switch_bit3_i, card_num_switch_bit2_i,
                       card_num_switch_bit1_i, card_num_switch_bit0_i};
  assign card_num   = swcfg_q ? switch_num : jumper_num;
  assign chain      = mode_q[1];
  assign is_ctrl    = (rx_char_i < 8'h20);
  assign is_query   = (rx_char_i == 8'h02) || (rx_char_i == 8'h03) ||
                      (rx_char_i == 8'h05) || (rx_char_i == 8'h06) ||
                      (rx_char_i == 8'h07) || (rx_char_i == 8'h10) ||
                      (rx_char_i == 8'h16) || (rx_char_i == 8'h19);
  assign scan       = (scan_cnt_q == SCAN_CYCLES - 1);
  assign off        = paddr_i - BUS_BASE;
  // Only this card's 32-byte window hits; addresses outside it are still answered, with an error.
  assign bus_hit    = (paddr_i >= BUS_BASE) && (paddr_i < BUS_BASE + 12'h020);

  hex_digit_decode u_hex (
    .char_i  (rx_char_i),
    .value_o (digit),
    .valid_o (digit_ok)
  );

  ////////////////////////////////////////////////////////////////////////
  // Scan divider: carriage returns inside one period act together.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      scan_cnt_q  <= 32'h0000_0000;
      scan_tick_o <= 1'b0;
    end else begin
      scan_tick_o <= scan;
      if (scan) begin
        scan_cnt_q <= 32'h0000_0000;
      end else begin
        scan_cnt_q <= scan_cnt_q + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Character decoder. Selection is staged and committed at the scan.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rst_seen_q   <= 1'b0;
      chain_q      <= 1'b0;
      addressed_q  <= 1'b0;
      all_q        <= 1'b0;
      at_seen_q    <= 1'b0;
      sel_pend_q   <= 1'b0;
      sel_all_q    <= 1'b0;
      sel_hit_q    <= 1'b0;
      line_has_q   <= 1'b0;
      cr_pend_q    <= 1'b0;
      err_q        <= 1'b0;
      ctrl_seen_q  <= 1'b0;
      query_rej_q  <= 1'b0;
      last_rx_q    <= 8'h00;
      cmd_valid_o  <= 1'b0;
      cmd_char_o   <= 8'h00;
      ctrl_valid_o <= 1'b0;
      ctrl_char_o  <= 8'h00;
      line_go_o    <= 1'b0;
      line_noop_o  <= 1'b0;
    end else begin
      cmd_valid_o  <= 1'b0;
      ctrl_valid_o <= 1'b0;
      line_go_o    <= 1'b0;
      line_noop_o  <= 1'b0;
      // Card number is sampled after reset so a strap is never reset data.
      // Entering chain mode counts as a power-up in chain mode, since the
      // mode itself resets to single-card operation.
      chain_q <= chain;
      if (!rst_seen_q || (chain && !chain_q)) begin
        rst_seen_q  <= 1'b1;
        addressed_q <= !chain || (card_num == 4'h0);
      end
      // Commit first, so a character landing on the scan edge is kept for
      // the next line instead of being cleared with the old one.
      if (scan && cr_pend_q) begin
        cr_pend_q  <= 1'b0;
        line_has_q <= 1'b0;
        sel_pend_q <= 1'b0;
        line_go_o  <= line_has_q;
        line_noop_o <= !line_has_q;
        if (sel_pend_q) begin
          all_q       <= sel_all_q;
          addressed_q <= sel_all_q ? (card_num == 4'h0) : sel_hit_q;
        end
      end
      if (rx_valid_i) begin
        last_rx_q <= rx_char_i;
        if (at_seen_q) begin
          at_seen_q <= 1'b0;
          if (rx_char_i == `CH_AT) begin
            sel_pend_q <= 1'b1;
            sel_all_q  <= 1'b1;
          end else if (rx_char_i == `CH_CR) begin
            err_q     <= 1'b1;
            cr_pend_q <= 1'b1;
          end else if (digit_ok) begin
            sel_pend_q <= 1'b1;
            sel_all_q  <= 1'b0;
            sel_hit_q  <= (digit == card_num);
          end else begin
            err_q <= 1'b1;
          end
        end else if (chain && rx_char_i == `CH_AT) begin
          at_seen_q <= 1'b1;
        end else if (rx_char_i == `CH_CR) begin
          cr_pend_q <= 1'b1;
        end else if (is_ctrl) begin
          if (is_query) begin
            // Queries go to the addressed card, and are rejected while all cards are selected in chain mode.
            if (chain && all_q) begin
              query_rej_q <= 1'b1;
            end else if (addressed_q) begin
              ctrl_valid_o <= 1'b1;
              ctrl_char_o  <= rx_char_i;
            end
          end else begin
            ctrl_valid_o <= 1'b1;
            ctrl_char_o  <= rx_char_i;
            ctrl_seen_q  <= 1'b1;
          end
        end else if (addressed_q || all_q || !chain) begin
          cmd_valid_o <= 1'b1;
          cmd_char_o  <= rx_char_i;
          line_has_q  <= 1'b1;
        end
        // Unaddressed alphanumerics fall through and are dropped.
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs toward the host; in chain mode non-addressed cards float them.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      tx_data_o    <= 1'b0;
      tx_data_oe_o <= 1'b0;
      rts_o        <= 1'b0;
      rts_oe_o     <= 1'b0;
      tx_hold_o    <= 1'b0;
      last_tx_q    <= 8'h00;
    end else begin
      tx_data_oe_o <= !chain || addressed_q;
      rts_oe_o     <= !chain || addressed_q;
      tx_data_o    <= tx_valid_i;
      rts_o        <= tx_rts_i;
      // CTS from the host is honoured unless mode 3 is set.
      tx_hold_o    <= (mode_q != `MODE_CHAIN_NOCTS) && !cts_i;
      if (tx_valid_i) begin
        last_tx_q <= tx_char_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave, one wait-free access phase.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mode_q    <= `CTRL_MODE_RST;
      swcfg_q   <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      line_q    <= 1'b0;
    end else begin
      line_q    <= cr_pend_q;
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      // Writes land at the edge that completes the transfer, not at setup.
      if (psel_i && penable_i && pready_o && pwrite_i && bus_hit &&
          (off == `REG_CTRL_OFF)) begin
        mode_q  <= pwdata_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
        swcfg_q <= pwdata_i[`CTRL_SWCFG_BIT];
      end
      if (psel_i && !penable_i) begin
        if (!bus_hit) begin
          pslverr_o <= 1'b1;
        end else if (off == `REG_CTRL_OFF) begin
          prdata_o <= {29'h0000_0000, swcfg_q, mode_q};
        end else if (off == `REG_STATUS_OFF) begin
          prdata_o <= {26'h000_0000, query_rej_q, ctrl_seen_q, err_q,
                       line_q, all_q, addressed_q};
        end else if (off == `REG_RXCHAR_OFF) begin
          prdata_o <= {24'h00_0000, last_rx_q};
        end else if (off == `REG_TXCHAR_OFF) begin
          prdata_o <= {24'h00_0000, last_tx_q};
        end else if (off == `REG_CARD_OFF) begin
          prdata_o <= {28'h000_0000, card_num};
        end else begin
          pslverr_o <= 1'b1;
        end
      end
    end
  end
endmodule // card_select
`default_nettype wire

/* File: card_select_defs.vh */
// Constants for the multi-card serial addressing block.
`ifndef CARD_SELECT_DEFS_VH
`define CARD_SELECT_DEFS_VH
// APB register byte offsets.
`define REG_CTRL_OFF       12'h000
`define REG_STATUS_OFF     12'h004
`define REG_RXCHAR_OFF     12'h008
`define REG_TXCHAR_OFF     12'h00C
`define REG_CARD_OFF       12'h010
// Control register fields and reset values.
`define CTRL_MODE_LSB      0
`define CTRL_MODE_MSB      1
`define CTRL_SWCFG_BIT     2
`define CTRL_MODE_RST      2'h0
// Status register fields.
`define ST_ADDR_BIT        0
`define ST_ALL_BIT         1
`define ST_LINE_BIT        2
`define ST_ERR_BIT         3
`define ST_CTRL_BIT        4
`define ST_QUERY_BIT       5
// Multi-card mode values.
`define MODE_CHAIN         2'h2
`define MODE_CHAIN_NOCTS   2'h3
// Characters.
`define CH_AT              8'h40
`define CH_CR              8'h0D
`define CH_BS              8'h08
// Command scan period.
`define SCAN_PERIOD_US     1000
`define CLK_MHZ            20
`define SCAN_CYCLES        (`SCAN_PERIOD_US * `CLK_MHZ)
`endif

/* File: card_select_monitor.sv */
// Port-level assertions for the card selection block.
`timescale 1ns/1ns
`default_nettype none
module card_select_monitor #(
  parameter SCAN_CYCLES = 8
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        rx_valid_i,
  input wire logic [7:0]  rx_char_i,
  input wire logic        cts_i,
  input wire logic        tx_hold_o,
  input wire logic        scan_tick_o,
  input wire logic        cmd_valid_o,
  input wire logic [7:0]  cmd_char_o,
  input wire logic        ctrl_valid_o,
  input wire logic [7:0]  ctrl_char_o,
  input wire logic        line_go_o,
  input wire logic        line_noop_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [1:0] mode_q;
  int         cnt_q;
  logic       seen_q;
  // Mode is mirrored from bus writes, since the block does not show it at its pins.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mode_q <= 2'h0;
      cnt_q  <= 0;
      seen_q <= 1'b0;
    end else begin
      if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h000) begin
        mode_q <= pwdata_i[1:0];
      end
      cnt_q  <= scan_tick_o ? 0 : cnt_q + 1;
      seen_q <= seen_q | scan_tick_o;
    end
  end
  pready_one_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("bus answer missing");
  bad_addr_a: assert property (psel_i && !penable_i && paddr_i == 12'h014 |=> pslverr_o)
    else $error("unmapped address accepted");
  scan_period_a: assert property (scan_tick_o && seen_q |-> cnt_q == SCAN_CYCLES - 1)
    else $error("scan period wrong");
  line_at_scan_a: assert property (line_go_o || line_noop_o |-> scan_tick_o || $past(scan_tick_o))
    else $error("line processed off scan");
  cmd_echo_a: assert property (cmd_valid_o |-> $past(rx_valid_i) && cmd_char_o == $past(rx_char_i))
    else $error("command char mismatch");
  ctrl_echo_a: assert property (ctrl_valid_o |-> $past(rx_valid_i) && ctrl_char_o == $past(rx_char_i)
    && ctrl_char_o < 8'h20)
    else $error("control char mismatch");
  hold_off_a: assert property (mode_q == 2'h3 ##1 mode_q == 2'h3 |-> !tx_hold_o)
    else $error("hold raised in mode three");
  hold_on_a: assert property (mode_q == 2'h2 && !cts_i |=> tx_hold_o)
    else $error("hold missing in mode two");
endmodule // card_select_monitor
bind card_select card_select_monitor #(.SCAN_CYCLES(SCAN_CYCLES)) mon (.*);
`default_nettype wire

/* File: hex_digit_decode.v */
// Decoder from an ASCII character to a hexadecimal digit value.
`timescale 1ns/1ns
`default_nettype none
module hex_digit_decode (
  input  wire [7:0] char_i,
  output reg  [3:0] value_o,
  output reg        valid_o
);
  always @* begin
    value_o = 4'h0;
    valid_o = 1'b1;
    if (char_i >= 8'h30 && char_i <= 8'h39) begin
      value_o = char_i[3:0];
    end else if ((char_i >= 8'h41 && char_i <= 8'h46) ||
                 (char_i >= 8'h61 && char_i <= 8'h66)) begin
      value_o = char_i[3:0] + 4'h9;
    end else begin
      valid_o = 1'b0;
    end
  end
endmodule // hex_digit_decode
`default_nettype wire

/* File: host_model.sv */
// Host computer on the serial chain: sends characters and drives clear-to-send.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic       clk_i,
  output var  logic       rx_valid_o,
  output var  logic [7:0] rx_char_o,
  output var  logic       cts_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o  = 8'h00;
    cts_o      = 1'b1;
  end
  // The released line shows the inverse so a stale character is never mistaken for data.
  task automatic send(input logic [7:0] c);
    rx_valid_o <= 1'b1;
    rx_char_o  <= c;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_char_o  <= ~c;
    // The gap lets the card finish one character before the next arrives.
    repeat (2) @(posedge clk_i);
  endtask
  task automatic hold(input logic h);
    cts_o <= !h;
  endtask
endmodule // host_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the card selection block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        sys_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, tx_data_o, tx_data_oe_o, rts_o, rts_oe_o, tx_hold_o;
  logic        scan_tick_o, cmd_valid_o, ctrl_valid_o, line_go_o, line_noop_o;
  logic [7:0]  cmd_char_o, ctrl_char_o, rx_char_i, last_c;
  logic        rx_valid_i, cts_i;
  logic        tx_valid_i = 1'b0;
  logic        tx_rts_i = 1'b1;
  logic [7:0]  tx_char_i = 8'h55;
  logic [3:0]  jmp = 4'h0;
  logic [3:0]  sw = 4'hF;
  int          fail_count, check_count, n_cmd, n_ctrl, n_go, n_noop;
  always #25 sys_clk_i = ~sys_clk_i;
  card_select #(.SCAN_CYCLES(8)) dut (.*,
    .card_num_jumper_bit0_i(jmp[0]), .card_num_jumper_bit1_i(jmp[1]),
    .card_num_jumper_bit2_i(jmp[2]), .card_num_jumper_bit3_i(jmp[3]),
    .card_num_switch_bit0_i(sw[0]), .card_num_switch_bit1_i(sw[1]),
    .card_num_switch_bit2_i(sw[2]), .card_num_switch_bit3_i(sw[3]));
  host_model host (.clk_i(sys_clk_i), .rx_valid_o(rx_valid_i), .rx_char_o(rx_char_i),
    .cts_o(cts_i));
  always @(posedge sys_clk_i) begin
    if (cmd_valid_o === 1'b1) last_c = cmd_char_o;
    n_cmd += (cmd_valid_o === 1'b1);
    n_ctrl += (ctrl_valid_o === 1'b1);
    n_go += (line_go_o === 1'b1);
    n_noop += (line_noop_o === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      fail_count++;
      end_sim();
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                    input logic ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r & m, x);
    check({31'h0, e}, {31'h0, ex});
  endtask
  task automatic wr(input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, 12'h000, d, r, e);
  endtask
  task automatic do_reset(input logic [3:0] j);
    jmp <= j;
    sw <= ~j;
    rst_b_i <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
  endtask
  // Sends a line and its carriage return, then waits for the next scan to process it.
  task automatic send_line(input string s);
    int g, k;
    g = n_go + n_noop;
    foreach (s[i]) host.send(s[i]);
    repeat (20) @(posedge sys_clk_i);
    host.send(8'h0D);
    for (k = 0; k < 30 && n_go + n_noop == g; k++) @(posedge sys_clk_i);
    if (n_go + n_noop == g) begin
      fail_count++;
      end_sim();
    end
    repeat (2) @(posedge sys_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_first;
    int c;
    do_reset(4'h0);
    rd(12'h010, 32'hF, 32'h0, 1'b0);
    rd(12'h004, 32'h1, 32'h1, 1'b0);
    rd(12'h014, 32'hFFFF_FFFF, 32'h0, 1'b1);
    rd(12'h020, 32'hFFFF_FFFF, 32'h0, 1'b1);
    c = n_cmd;
    send_line("@5");
    check(n_cmd - c, 2);
    wr(32'h2);
    send_line("@0");
    rd(12'h004, 32'h1, 32'h1, 1'b0);
    $display("first done");
  endtask
  task automatic t_chain;
    int    c, o;
    string s;
    string hx;
    hx = "0123456789ABCDEF";
    s = "@0";
    do_reset(4'h6);
    wr(32'h2);
    rd(12'h010, 32'hF, 32'h6, 1'b0);
    wr(32'h6);
    rd(12'h010, 32'hF, 32'h9, 1'b0);
    wr(32'h2);
    rd(12'h004, 32'h1, 32'h0, 1'b0);
    c = n_cmd;
    o = n_noop;
    send_line("A");
    check(n_cmd - c, 0);
    check(n_noop - o, 1);
    check({31'h0, tx_data_oe_o}, 32'h0);
    check({31'h0, rts_oe_o}, 32'h0);
    c = n_ctrl;
    host.send(8'h01);
    check(n_ctrl - c, 1);
    for (int d = 0; d < 16; d++) begin
      s[1] = hx[d];
      send_line(s);
      rd(12'h004, 32'h1, {31'h0, d == 6}, 1'b0);
    end
    send_line("@6");
    send_line("@G");
    rd(12'h004, 32'h19, 32'h19, 1'b0);
    host.send("@");
    host.send("3");
    rd(12'h004, 32'h1, 32'h1, 1'b0);
    send_line("");
    rd(12'h004, 32'h1, 32'h0, 1'b0);
    send_line("@6");
    c = n_cmd;
    o = n_go;
    tx_valid_i <= 1'b1;
    send_line("A");
    check(n_cmd - c, 1);
    check({24'h0, last_c}, 32'h41);
    check(n_go - o, 1);
    check({31'h0, tx_data_oe_o}, 32'h1);
    check({31'h0, rts_oe_o}, 32'h1);
    check({31'h0, tx_data_o}, 32'h1);
    check({31'h0, rts_o}, 32'h1);
    rd(12'h00C, 32'hFF, 32'h55, 1'b0);
    rd(12'h008, 32'hFF, 32'h0D, 1'b0);
    c = n_ctrl;
    host.send(8'h02);
    check(n_ctrl - c, 1);
    send_line("@@");
    rd(12'h004, 32'h23, 32'h2, 1'b0);
    c = n_cmd;
    send_line("B");
    check(n_cmd - c, 1);
    c = n_ctrl;
    host.send(8'h02);
    check(n_ctrl - c, 0);
    rd(12'h004, 32'h20, 32'h20, 1'b0);
    send_line("@6");
    rd(12'h004, 32'h3, 32'h1, 1'b0);
    wr(32'h3);
    host.hold(1'b1);
    repeat (3) @(posedge sys_clk_i);
    check({31'h0, tx_hold_o}, 32'h0);
    wr(32'h2);
    repeat (3) @(posedge sys_clk_i);
    check({31'h0, tx_hold_o}, 32'h1);
    host.hold(1'b0);
    $display("chain done");
  endtask
  initial begin
    #4_000_000;
    fail_count++;
    end_sim();
  end
  initial begin
    t_first();
    t_chain();
    end_sim();
  end
endmodule // tb
`default_nettype wire
